// *** rtl/lfbp_ctrl.sv ***
// lcd drive, frame timing and power save control with ahb-lite registers
//
// Functional notes
// - generator enable bit starts and stops generator
// - bias bit chooses third or half bias
// - waveforms use four or three drive levels
// - frame rate is subclock over ratio times commons
// - divider field: stop, 512, 256, 128
// - duty bit selects four or three commons
// - top control bit selects core power save
// - power save exists only on mask variant
`timescale 1ns/1ps
module lfbp_ctrl #(
    parameter bit MASK_VARIANT = 1'b1 // 1: mask part, 0: flash part
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic crystal_subclock,
    input wire logic [4*lfbp_pkg::LFBP_SEG_COUNT-1:0] seg_pattern,
    output logic drive_voltage_gen_enable,
    output logic bias_third,
    output logic core_low_voltage_select,
    output logic frame_tick,
    output lfbp_pkg::lfbp_drive_s drive
);
    logic [7:0] lcd_display_control; // software control byte
    logic wr_pend; // write data phase in progress
    logic [31:0] wr_addr; // address captured for that write
    logic accept; // address phase taken this cycle
    logic ctrl_hit; // pending write targets control register
    logic [7:0] ctrl_view; // control as a read would see it
    logic [31:0] next_rdata;
    logic xt_level; // filtered subclock level, unused beyond sync
    logic xt_rise; // one pulse per subclock rising edge
    lfbp_pkg::lfbp_freq_e freq;
    logic [9:0] reference_clock_ratio;
    logic [1:0] com_last; // last common index for selected duty
    logic run; // frame timing active
    logic [9:0] div_cnt; // subclock edges within one common slot
    logic [1:0] com_idx; // common line now selected
    logic polarity; // ac inversion phase, flips each frame
    logic div_last;
    logic com_last_now;
    logic scan; // panel is being driven
    lfbp_pkg::lfbp_drive_s next_drive;

    // subclock comes from a pin, so it is synchronised first
    lfbp_sync_edge u_xt_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .din(crystal_subclock),
        .level(xt_level),
        .rise(xt_rise)
    );

    // ahb-lite address phase is taken when selected, nonseq or seq, and ready
    assign accept = hsel & htrans[1] & hready;
    assign ctrl_hit = wr_pend & (wr_addr == lfbp_pkg::LFBP_CTRL_ADDR);

    // zero wait state slave: always ready, always okay
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp <= lfbp_pkg::LFBP_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= lfbp_pkg::LFBP_HRESP_OKAY;
        end
    end

    // capture write address; data arrives in the following cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
        end else begin
            wr_pend <= accept & hwrite;
            if (accept & hwrite) begin
                wr_addr <= haddr;
            end
        end
    end

    // control register; only word writes are expected, low byte used
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lcd_display_control <= lfbp_pkg::LFBP_CTRL_RESET;
        end else if (ctrl_hit) begin
            lcd_display_control <= hwdata[7:0] & lfbp_pkg::LFBP_CTRL_WMASK;
        end
    end

    // forward a write in its data phase so a read right behind it is fresh
    always_comb begin
        ctrl_view = lcd_display_control;
        if (ctrl_hit) begin
            ctrl_view = hwdata[7:0] & lfbp_pkg::LFBP_CTRL_WMASK;
        end
        next_rdata = 32'h0000_0000;
        if (haddr == lfbp_pkg::LFBP_CTRL_ADDR) begin
            next_rdata[7:0] = ctrl_view;
        end else if (haddr == lfbp_pkg::LFBP_STATUS_ADDR) begin
            next_rdata[lfbp_pkg::LFBP_ST_COM_LSB +: 2] = com_idx;
            next_rdata[lfbp_pkg::LFBP_ST_RUN_BIT] = run;
            next_rdata[lfbp_pkg::LFBP_ST_POL_BIT] = polarity;
            next_rdata[lfbp_pkg::LFBP_ST_PSAVE_BIT] = core_low_voltage_select;
            next_rdata[lfbp_pkg::LFBP_ST_MASK_BIT] = MASK_VARIANT;
        end
    end

    // read data is loaded at the address phase and stands in the data phase;
    // unmapped addresses read zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (accept & ~hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // generator, bias and power save controls follow the register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            drive_voltage_gen_enable <= 1'b0;
            bias_third <= 1'b0;
            core_low_voltage_select <= 1'b0;
        end else begin
            drive_voltage_gen_enable <=
                lcd_display_control[lfbp_pkg::LFBP_GEN_EN_BIT];
            bias_third <= lcd_display_control[lfbp_pkg::LFBP_BIAS_BIT];
            // the flash part has no save mode, so the bit has no effect;
            // ordering against the generator is left to software
            core_low_voltage_select <= MASK_VARIANT &
                lcd_display_control[lfbp_pkg::LFBP_PSAVE_BIT];
        end
    end

    // divider field and duty decode
    always_comb begin
        freq = lfbp_pkg::lfbp_freq_e'(lcd_display_control[5:4]);
        reference_clock_ratio = lfbp_pkg::LFBP_ND_512;
        unique case (freq)
            lfbp_pkg::LFBP_FREQ_STOP: begin
                reference_clock_ratio = lfbp_pkg::LFBP_ND_512;
            end
            lfbp_pkg::LFBP_FREQ_512: begin
                reference_clock_ratio = lfbp_pkg::LFBP_ND_512;
            end
            lfbp_pkg::LFBP_FREQ_256: begin
                reference_clock_ratio = lfbp_pkg::LFBP_ND_256;
            end
            lfbp_pkg::LFBP_FREQ_128: begin
                reference_clock_ratio = lfbp_pkg::LFBP_ND_128;
            end
        endcase
        // duty bit set means three commons
        if (lcd_display_control[lfbp_pkg::LFBP_DUTY_BIT]) begin
            com_last = lfbp_pkg::LFBP_COM_LAST_3;
        end else begin
            com_last = lfbp_pkg::LFBP_COM_LAST_4;
        end
    end

    assign run = (freq != lfbp_pkg::LFBP_FREQ_STOP);
    assign div_last = (div_cnt == (reference_clock_ratio - 10'h001));
    // >= so a duty change from four to three never strands the scan
    assign com_last_now = (com_idx >= com_last);

    // slot and common counters: ratio edges per slot, one slot per common
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_cnt <= 10'h000;
            com_idx <= 2'h0;
        end else if (!run) begin
            div_cnt <= 10'h000;
            com_idx <= 2'h0;
        end else if (xt_rise) begin
            if (div_last || div_cnt > reference_clock_ratio) begin
                div_cnt <= 10'h000;
                if (com_last_now) begin
                    com_idx <= 2'h0;
                end else begin
                    com_idx <= com_idx + 2'h1;
                end
            end else begin
                div_cnt <= div_cnt + 10'h001;
            end
        end
    end

    // frame pulse and ac polarity once per ratio times commons edges
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            frame_tick <= 1'b0;
            polarity <= 1'b0;
        end else begin
            frame_tick <= run & xt_rise & div_last & com_last_now;
            if (run & xt_rise & div_last & com_last_now) begin
                polarity <= ~polarity;
            end
        end
    end

    // scanning needs display enable, generator and running frame timing
    assign scan = lcd_display_control[lfbp_pkg::LFBP_DISP_EN_BIT] &
                  lcd_display_control[lfbp_pkg::LFBP_GEN_EN_BIT] & run;

    // level pattern: selected common swings between v3 and vss; under half
    // bias the middle level v1 stands for both inner levels
    always_comb begin
        next_drive = '0;
        for (int k = 0; k < 4; k++) begin
            if (!scan) begin
                next_drive.com[k] = lfbp_pkg::LFBP_LVL_VSS;
            end else if (com_idx == k[1:0]) begin
                next_drive.com[k] = polarity ? lfbp_pkg::LFBP_LVL_VSS
                                             : lfbp_pkg::LFBP_LVL_V3;
            end else if (bias_third) begin
                next_drive.com[k] = polarity ? lfbp_pkg::LFBP_LVL_V2
                                             : lfbp_pkg::LFBP_LVL_V1;
            end else begin
                next_drive.com[k] = lfbp_pkg::LFBP_LVL_V1;
            end
        end
        for (int j = 0; j < lfbp_pkg::LFBP_SEG_COUNT; j++) begin
            if (!scan) begin
                next_drive.seg[j] = lfbp_pkg::LFBP_LVL_VSS;
            end else if (seg_pattern[4*j + int'(com_idx)]) begin
                next_drive.seg[j] = polarity ? lfbp_pkg::LFBP_LVL_V3
                                             : lfbp_pkg::LFBP_LVL_VSS;
            end else if (bias_third) begin
                next_drive.seg[j] = polarity ? lfbp_pkg::LFBP_LVL_V1
                                             : lfbp_pkg::LFBP_LVL_V2;
            end else begin
                next_drive.seg[j] = lfbp_pkg::LFBP_LVL_V1;
            end
        end
    end

    // registered pin levels
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            drive <= '0;
        end else begin
            drive <= next_drive;
        end
    end

    // checks on the control path and scan timing
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_gen_write_follow: assert property (
        ctrl_hit |-> ##2 (drive_voltage_gen_enable == $past(hwdata[0], 2)))
        else $error("generator enable does not follow write");

    a_bias_write_follow: assert property (
        ctrl_hit |-> ##2 (bias_third == $past(hwdata[2], 2)))
        else $error("bias select does not follow write");

    a_psave_write: assert property (
        ctrl_hit |-> ##2
            (core_low_voltage_select == (MASK_VARIANT & $past(hwdata[7], 2))))
        else $error("power save select does not follow write");

    a_flash_no_psave: assert property (
        (MASK_VARIANT == 1'b0) |-> !core_low_voltage_select)
        else $error("flash variant entered power save");

    a_stop_holds: assert property (
        !run |=> (div_cnt == 10'h000) && (com_idx == 2'h0) && !frame_tick)
        else $error("frame timing moves while stopped");

    a_frame_wrap: assert property (
        frame_tick |-> (div_cnt == 10'h000) && (com_idx == 2'h0))
        else $error("frame pulse not at scan wrap");

    a_duty_three_wrap: assert property (
        (run && xt_rise && div_last && com_idx == 2'h2 &&
         lcd_display_control[3]) |=> (com_idx == 2'h0))
        else $error("three common scan did not wrap");

    a_display_gate: assert property (
        !lcd_display_control[1] |=> (drive == '0))
        else $error("panel driven while display disabled");

    a_half_bias_levels: assert property (
        (!bias_third && scan) |=> (drive.com[0] != lfbp_pkg::LFBP_LVL_V2) &&
            (drive.com[1] != lfbp_pkg::LFBP_LVL_V2) &&
            (drive.seg[0] != lfbp_pkg::LFBP_LVL_V2))
        else $error("half bias used a third level");

    a_hready_okay: assert property (
        hreadyout && (hresp == lfbp_pkg::LFBP_HRESP_OKAY))
        else $error("slave stalled or answered error");

    c_frame_done: cover property (frame_tick);
    c_psave_on: cover property (core_low_voltage_select && scan);
    c_com3_scan: cover property (scan && com_idx == 2'h3);
    c_status_read: cover property (
        accept && !hwrite && haddr == lfbp_pkg::LFBP_STATUS_ADDR);
endmodule : lfbp_ctrl

// *** rtl/lfbp_sync_edge.sv ***
// three-stage input synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module lfbp_sync_edge (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic din,
    output logic level,
    output logic rise
);
    logic s1; // first stage, read only by s2
    logic s2;
    logic s3;

    // plain shift chain; s1 feeds s2 and nothing else
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            level <= 1'b0;
            rise <= 1'b0;
        end else begin
            if (s2 == s3) begin
                level <= s2;
            end
            rise <= s2 & s3 & ~level;
        end
    end
endmodule : lfbp_sync_edge

// *** shared/lfbp_pkg.sv ***
// shared constants and carriers for the lcd frame, bias and power save control
package lfbp_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [31:0] LFBP_CTRL_IDX = 32'h0000fee7;
    localparam logic [31:0] LFBP_STATUS_IDX = 32'h0000fee8;
    localparam logic [31:0] LFBP_CTRL_ADDR = {LFBP_CTRL_IDX[29:0], 2'b00};
    localparam logic [31:0] LFBP_STATUS_ADDR = {LFBP_STATUS_IDX[29:0], 2'b00};

    // control register fields
    localparam int LFBP_GEN_EN_BIT = 0;
    localparam int LFBP_DISP_EN_BIT = 1;
    localparam int LFBP_BIAS_BIT = 2;
    localparam int LFBP_DUTY_BIT = 3;
    localparam int LFBP_FREQ_LO_BIT = 4;
    localparam int LFBP_FREQ_HI_BIT = 5;
    localparam int LFBP_PSAVE_BIT = 7;

    // reset value and writable bits (bit 6 is reserved and reads zero)
    localparam logic [7:0] LFBP_CTRL_RESET = 8'h00;
    localparam logic [7:0] LFBP_CTRL_WMASK = 8'hbf;

    // status register fields
    localparam int LFBP_ST_COM_LSB = 0;
    localparam int LFBP_ST_RUN_BIT = 2;
    localparam int LFBP_ST_POL_BIT = 3;
    localparam int LFBP_ST_PSAVE_BIT = 4;
    localparam int LFBP_ST_MASK_BIT = 5;

    // reference clock ratios
    localparam logic [9:0] LFBP_ND_512 = 10'h200;
    localparam logic [9:0] LFBP_ND_256 = 10'h100;
    localparam logic [9:0] LFBP_ND_128 = 10'h080;

    // last common index for four and three common lines
    localparam logic [1:0] LFBP_COM_LAST_4 = 2'h3;
    localparam logic [1:0] LFBP_COM_LAST_3 = 2'h2;

    // drive level codes
    localparam logic [1:0] LFBP_LVL_VSS = 2'h0;
    localparam logic [1:0] LFBP_LVL_V1 = 2'h1;
    localparam logic [1:0] LFBP_LVL_V2 = 2'h2;
    localparam logic [1:0] LFBP_LVL_V3 = 2'h3;

    // segment pins handled and ahb encodings
    localparam int LFBP_SEG_COUNT = 2;
    localparam logic [1:0] LFBP_HTRANS_NONSEQ = 2'h2;
    localparam logic LFBP_HRESP_OKAY = 1'b0;

    // frame divider field codes
    typedef enum logic [1:0] {
        LFBP_FREQ_STOP = 2'b00,
        LFBP_FREQ_512 = 2'b01,
        LFBP_FREQ_256 = 2'b10,
        LFBP_FREQ_128 = 2'b11
    } lfbp_freq_e;

    // level code per common and per segment pin
    typedef struct packed {
        logic [3:0][1:0] com;
        logic [LFBP_SEG_COUNT-1:0][1:0] seg;
    } lfbp_drive_s;

endpackage : lfbp_pkg

// *** tb/lfbp_panel_model.sv ***
// segment glass model: decodes lit segments back out of the drive levels
`timescale 1ns/1ps
module lfbp_panel_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic three_com, // bench setting: commons 0..2 only
    input wire logic half_bias, // bench setting: half bias expected
    input wire logic [7:0] seg_pattern,
    input wire lfbp_pkg::lfbp_drive_s drive,
    output logic [15:0] faults, // scans that decoded wrongly
    output logic [15:0] looks // scans that were examined
);
    // a passive glass: it only judges cycles in which something is driven
    always @(posedge ref_clk or posedge reset) begin
        int sel;
        int nsel;
        logic bad;
        logic lit;
        logic [1:0] lv;
        if (reset) begin
            faults <= 16'h0000;
            looks <= 16'h0000;
        end else if (drive !== '0) begin
            sel = 0;
            nsel = 0;
            bad = 1'b0;
            for (int k = 0; k < 4; k++) begin
                lv = drive.com[k];
                // an unused fourth common is not judged at third duty
                if (k < 3 || !three_com) begin
                    if (lv == lfbp_pkg::LFBP_LVL_VSS ||
                        lv == lfbp_pkg::LFBP_LVL_V3) begin
                        sel = k;
                        nsel++;
                    end
                    if (half_bias && lv == lfbp_pkg::LFBP_LVL_V2)
                        bad = 1'b1;
                end
            end
            // exactly one common may sit at an extreme level
            if (nsel != 1) bad = 1'b1;
            for (int j = 0; j < 2; j++) begin
                lv = drive.seg[j];
                lit = (lv == 2'h0 || lv == 2'h3) && lv != drive.com[sel];
                if (half_bias && lv == lfbp_pkg::LFBP_LVL_V2)
                    bad = 1'b1;
                if (lit !== seg_pattern[4*j+sel]) bad = 1'b1;
            end
            faults <= faults + 16'(bad);
            looks <= looks + 16'h0001;
        end
    end
endmodule : lfbp_panel_model

// *** tb/tb_lcd_frame_bias_powersave_ctrl.sv ***
// self-checking bench for the lcd frame, bias and power save control
`timescale 1ns/1ps
module tb_lcd_frame_bias_powersave_ctrl;
    localparam int SUB = 6; // ref clock cycles per subclock period
    localparam logic [31:0] CA = lfbp_pkg::LFBP_CTRL_ADDR;
    localparam logic [31:0] SA = lfbp_pkg::LFBP_STATUS_ADDR;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic crystal_subclock = 1'b0;
    logic [7:0] seg_pattern = 8'h00;
    logic drive_voltage_gen_enable;
    logic bias_third;
    logic core_low_voltage_select;
    logic frame_tick;
    lfbp_pkg::lfbp_drive_s drive;
    logic flash_core; // core select of the flash variant
    logic three_com = 1'b0; // model: duty setting in force
    logic half_bias = 1'b0; // model: bias setting in force
    logic [15:0] faults;
    logic [15:0] looks;
    int sub_cnt = 0;
    int errors = 0;
    int n_checks = 0;
    integer seed = 32'h293f;
    logic [31:0] d;
    logic [7:0] v;
    logic [1:0] code;
    int k;
    int nd;
    // reference model of the control byte, kept from the written words
    logic [7:0] ctrl_model = lfbp_pkg::LFBP_CTRL_RESET;

    // free-running crystal, stepped from the bench clock for exact counts
    // the bench clock keeps running beside the slow crystal, power save included
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        sub_cnt <= (sub_cnt == SUB - 1) ? 0 : sub_cnt + 1;
        crystal_subclock <= (sub_cnt < SUB / 2);
    end

    lfbp_ctrl #(.MASK_VARIANT(1'b1)) lfbp_ctrl_inst (
        .ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .crystal_subclock,
        .seg_pattern, .drive_voltage_gen_enable, .bias_third,
        .core_low_voltage_select, .frame_tick, .drive);
    // flash part on the same bus: its core select must never rise
    lfbp_ctrl #(.MASK_VARIANT(1'b0)) lfbp_ctrl_flash_inst (
        .ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(),
        .crystal_subclock, .seg_pattern, .drive_voltage_gen_enable(),
        .bias_third(), .core_low_voltage_select(flash_core),
        .frame_tick(), .drive());
    lfbp_panel_model lfbp_panel_model_inst (
        .ref_clk, .reset, .three_com, .half_bias, .seg_pattern, .drive,
        .faults, .looks);

    task automatic results;
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // waits for hready under a bound; a hung bus ends the run
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            errors++;
            results();
        end
    endtask : wait_ready

    // one single-word transfer; entered right after a rising edge
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= lfbp_pkg::LFBP_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        if (a == CA) ctrl_model = wd[7:0] & lfbp_pkg::LFBP_CTRL_WMASK;
        ahb(1'b1, a, wd, dummy);
    endtask : wr

    // counts cycles up to the next frame end pulse
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (frame_tick !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            errors++;
            results();
        end
    endtask : wait_tick

    // counts lit drive cycles and frame ticks over a quiet window; the
    // first edge is skipped, since drive and tick lag the write by one
    task automatic quiet(input string nm, input logic ticks_on);
        int n;
        int t;
        n = 0;
        t = 0;
        @(posedge ref_clk);
        repeat (4000) begin
            @(posedge ref_clk);
            if (drive !== '0) n++;
            if (frame_tick !== 1'b0) t++;
        end
        chk(nm, 32'h0, 32'(n));
        chk({nm, "_ticks"}, {31'h0, ticks_on}, {31'h0, t != 0});
    endtask : quiet

    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        chk("reset_outs", 32'h1, {drive_voltage_gen_enable, bias_third,
            core_low_voltage_select, frame_tick, hresp, hreadyout});
        ahb(1'b0, CA, 32'h0, d);
        chk("ctrl_reset", 32'(lfbp_pkg::LFBP_CTRL_RESET), d);
        // random readback, display bit kept clear so the glass stays dark
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed)) & 8'hfd;
            wr(CA, {24'hffffff, v});
            ahb(1'b0, CA, 32'h0, d);
            chk("ctrl_rd", {24'h0, ctrl_model}, d);
            repeat (3) @(posedge ref_clk);
            chk("ctrl_outs", {29'h0, v[7], v[2], v[0]}, {29'h0,
                core_low_voltage_select, bias_third,
                drive_voltage_gen_enable});
            chk("flash_core", 32'h0, {31'h0, flash_core});
            ahb(1'b0, SA, 32'h0, d);
            chk("status", {26'h0, 1'b1, v[7], 4'h0}, d & 32'h30);
        end
        // an unmapped word reads zero and leaves control untouched
        wr(CA + 32'h8, 32'hffffffff);
        ahb(1'b0, CA + 32'h8, 32'h0, d);
        chk("unmapped", 32'h0, d);
        ahb(1'b0, CA, 32'h0, d);
        chk("ctrl_kept", {24'h0, ctrl_model}, d);
        // each running divider code and both duties, glass dark in between
        for (int i = 0; i < 4; i++) begin
            wr(CA, 32'h0);
            repeat (3) @(posedge ref_clk);
            chk("dark", 32'h0, 32'(drive));
            code = (i == 3) ? 2'h3 : 2'(i + 1);
            three_com <= (i != 3);
            half_bias <= 1'($random(seed));
            seg_pattern <= 8'($random(seed));
            nd = 128 << (3 - code);
            @(posedge ref_clk);
            wr(CA, {24'h0, 2'h0, code, three_com, ~half_bias, 2'h3});
            wait_tick(k);
            wait_tick(k);
            chk("frame_len", 32'(nd * (three_com ? 3 : 4) * SUB),
                32'(k));
        end
        wr(CA, 32'h35);
        // display off darkens the glass but frame timing keeps running
        quiet("display_off", 1'b1);
        wr(CA, 32'h07);
        quiet("divider_stop", 1'b0);
        // no hold standby is entered, so no crystal idle clear is owed
        // generator and timing first, then the mode bit
        wr(CA, 32'h35);
        wr(CA, 32'hb5);
        repeat (3) @(posedge ref_clk);
        chk("psave_on", 32'h1, {31'h0, core_low_voltage_select});
        // leave power save and come back, settling between steps
        wr(CA, 32'h35);
        repeat (200) @(posedge ref_clk);
        chk("psave_off", 32'h0, {31'h0, core_low_voltage_select});
        wr(CA, 32'hb5);
        repeat (200) @(posedge ref_clk);
        chk("psave_again", 32'h1, {31'h0, core_low_voltage_select});
        // display on while in power save, third bias and four commons
        half_bias <= 1'b0;
        three_com <= 1'b0;
        wr(CA, 32'hb7);
        repeat (3) @(posedge ref_clk);
        chk("psave_scan", 32'h3, {30'h0, core_low_voltage_select,
            drive !== '0});
        chk("glass_faults", 32'h0, {16'h0, faults});
        chk("glass_seen", 32'h1, {31'h0, looks != 16'h0});
        results();
    end
endmodule : tb_lcd_frame_bias_powersave_ctrl
